// ### rtl/change_flag_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "pin_change_regs.vh"

module change_flag_bank #(
    parameter [7:0] IMPL_MASK = 8'hff
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] rise_en,
    input wire [7:0] fall_en,
    input wire [7:0] rise,
    input wire [7:0] fall,
    input wire wr_flags,
    input wire [7:0] wdata,
    output reg [7:0] flags,
    output wire any_event
);
    wire [7:0] hit;
    wire [7:0] next_flags;

    // flag set on enabled rising or falling edge; both may be enabled
    assign hit = ((rise & rise_en) | (fall & fall_en)) & IMPL_MASK;
    assign any_event = |hit;
    assign next_flags = ((wr_flags ? wdata : flags) | hit) & IMPL_MASK;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= `REG_RESET;
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end
endmodule

`default_nettype wire

// ### rtl/pin_change_interrupt.v
`timescale 1ns/100ps
`default_nettype none
`include "pin_change_regs.vh"

module pin_change_interrupt (
    input wire core_clk,
    input wire nrst,
    input wire clk_en,
    input wire [5:0] first_port_pin,
    input wire [7:4] second_port_pin,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg change_irq,
    output reg wake_req,
    output reg irq
);
    reg rst_meta;
    reg rst_n;
    reg [7:0] first_port_rise_enable;
    reg [7:0] first_port_fall_enable;
    reg [7:0] second_port_rise_enable;
    reg [7:0] second_port_fall_enable;
    reg change_irq_master_enable;
    reg [`EVT_WIDTH-1:0] irq_status;
    reg [`EVT_WIDTH-1:0] irq_mask;
    reg [31:0] next_prdata;
    reg next_err;
    wire [7:0] first_port_change_flags;
    wire [7:0] second_port_change_flags;
    wire [7:0] first_rise;
    wire [7:0] first_fall;
    wire [7:0] second_rise;
    wire [7:0] second_fall;
    wire first_event;
    wire second_event;
    wire change_irq_summary_flag;
    wire access;
    wire wr;
    wire [`EVT_WIDTH-1:0] events;
    wire [`EVT_WIDTH-1:0] next_status;
    wire [7:0] lead_pins;
    wire [7:0] lead_rise;
    wire [7:0] lead_fall;
    wire [1:0] tail_rise;
    wire [1:0] tail_fall;
    wire sel_first_rise;
    wire sel_first_fall;
    wire sel_second_rise;
    wire sel_second_fall;
    wire sel_control;
    wire sel_mask;
    wire wr_first_rise;
    wire wr_first_fall;
    wire wr_second_rise;
    wire wr_second_fall;
    wire wr_control;
    wire wr_mask;
    wire gated_request;

    // reset released through two flops so release is synchronous
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // synchronise and compare
    // first port pins sit above second port pins 7..6 in one vector
    assign lead_pins = {first_port_pin, second_port_pin[7:6]};

    pin_sync_edge #(
        .WIDTH(8)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(lead_pins),
        .rise(lead_rise),
        .fall(lead_fall)
    );

    // second port pins 5..4 share a second synchroniser instance
    pin_sync_edge #(
        .WIDTH(2)
    ) u_sync_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(second_port_pin[5:4]),
        .rise(tail_rise),
        .fall(tail_fall)
    );

    // split the synchroniser outputs back into per-port vectors
    assign first_rise[5:0] = lead_rise[7:2];
    assign first_fall[5:0] = lead_fall[7:2];
    assign second_rise[7:6] = lead_rise[1:0];
    assign second_fall[7:6] = lead_fall[1:0];
    assign second_rise[5:4] = tail_rise;
    assign second_fall[5:4] = tail_fall;

    // unused positions of the edge vectors are tied off
    assign first_rise[7:6] = 2'h0;
    assign first_fall[7:6] = 2'h0;
    assign second_rise[3:0] = 4'h0;
    assign second_fall[3:0] = 4'h0;

    // APB: every access is taken in its first access cycle and completes one cycle later
    assign access = psel & penable & ~pready;
    assign wr = access & pwrite;

    // address decode for the plain read-write registers
    assign sel_first_rise = (paddr == `ADDR_FIRST_RISE);
    assign sel_first_fall = (paddr == `ADDR_FIRST_FALL);
    assign sel_second_rise = (paddr == `ADDR_SECOND_RISE);
    assign sel_second_fall = (paddr == `ADDR_SECOND_FALL);
    assign sel_control = (paddr == `ADDR_IRQ_CONTROL);
    assign sel_mask = (paddr == `ADDR_IRQ_MASK);

    // write strobes, one per register, only in the taken access cycle
    assign wr_first_rise = wr & sel_first_rise;
    assign wr_first_fall = wr & sel_first_fall;
    assign wr_second_rise = wr & sel_second_rise;
    assign wr_second_fall = wr & sel_second_fall;
    assign wr_control = wr & sel_control;
    assign wr_mask = wr & sel_mask;

    // first port edges, rising or falling, flag set
    change_flag_bank #(
        .IMPL_MASK(`FIRST_PORT_MASK)
    ) u_first (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .rise_en(first_port_rise_enable),
        .fall_en(first_port_fall_enable),
        .rise(first_rise),
        .fall(first_fall),
        .wr_flags(wr && paddr == `ADDR_FIRST_FLAGS),
        .wdata(pwdata[7:0]),
        .flags(first_port_change_flags),
        .any_event(first_event)
    );

    // second port edges, rising or falling, flag set
    change_flag_bank #(
        .IMPL_MASK(`SECOND_PORT_MASK)
    ) u_second (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .rise_en(second_port_rise_enable),
        .fall_en(second_port_fall_enable),
        .rise(second_rise),
        .fall(second_fall),
        .wr_flags(wr && paddr == `ADDR_SECOND_FLAGS),
        .wdata(pwdata[7:0]),
        .flags(second_port_change_flags),
        .any_event(second_event)
    );

    assign change_irq_summary_flag = (|first_port_change_flags) | (|second_port_change_flags);

    // sticky event status, set beats write-one-to-clear
    assign events = {second_event, first_event};
    assign next_status = (wr && paddr == `ADDR_IRQ_STATUS) ?
        ((irq_status & ~pwdata[`EVT_WIDTH-1:0]) | events) : (irq_status | events);

    // first port rise enables, unimplemented bits stay zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_port_rise_enable <= `REG_RESET;
        end else if (clk_en && wr_first_rise) begin
            first_port_rise_enable <= pwdata[7:0] & `FIRST_PORT_MASK;
        end
    end

    // first port fall enables, unimplemented bits stay zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_port_fall_enable <= `REG_RESET;
        end else if (clk_en && wr_first_fall) begin
            first_port_fall_enable <= pwdata[7:0] & `FIRST_PORT_MASK;
        end
    end

    // second port rise enables, low nibble unimplemented
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            second_port_rise_enable <= `REG_RESET;
        end else if (clk_en && wr_second_rise) begin
            second_port_rise_enable <= pwdata[7:0] & `SECOND_PORT_MASK;
        end
    end

    // second port fall enables, low nibble unimplemented
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            second_port_fall_enable <= `REG_RESET;
        end else if (clk_en && wr_second_fall) begin
            second_port_fall_enable <= pwdata[7:0] & `SECOND_PORT_MASK;
        end
    end

    // master enable; summary bit of the control word is read only
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            change_irq_master_enable <= 1'b0;
        end else if (clk_en && wr_control) begin
            change_irq_master_enable <= pwdata[`CTRL_MASTER_BIT];
        end
    end

    // event mask, same layout as the status word
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= {`EVT_WIDTH{1'b0}};
        end else if (clk_en && wr_mask) begin
            irq_mask <= pwdata[`EVT_WIDTH-1:0];
        end
    end

    // sticky status, updated every enabled cycle so no event is missed
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= {`EVT_WIDTH{1'b0}};
        end else if (clk_en) begin
            irq_status <= next_status;
        end
    end

    // read mux; unmapped addresses answer with an error
    always @* begin
        next_prdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr == `ADDR_FIRST_RISE) begin
            next_prdata[7:0] = first_port_rise_enable;
        end else if (paddr == `ADDR_FIRST_FALL) begin
            next_prdata[7:0] = first_port_fall_enable;
        end else if (paddr == `ADDR_FIRST_FLAGS) begin
            next_prdata[7:0] = first_port_change_flags;
        end else if (paddr == `ADDR_SECOND_RISE) begin
            next_prdata[7:0] = second_port_rise_enable;
        end else if (paddr == `ADDR_SECOND_FALL) begin
            next_prdata[7:0] = second_port_fall_enable;
        end else if (paddr == `ADDR_SECOND_FLAGS) begin
            next_prdata[7:0] = second_port_change_flags;
        end else if (paddr == `ADDR_IRQ_CONTROL) begin
            next_prdata[`CTRL_MASTER_BIT] = change_irq_master_enable;
            next_prdata[`CTRL_SUMMARY_BIT] = change_irq_summary_flag;
        end else if (paddr == `ADDR_IRQ_STATUS) begin
            next_prdata[`EVT_WIDTH-1:0] = irq_status;
        end else if (paddr == `ADDR_IRQ_MASK) begin
            next_prdata[`EVT_WIDTH-1:0] = irq_mask;
        end else begin
            next_err = 1'b1;
        end
    end

    // bus answer: pready one cycle after penable rises
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= access;
            pslverr <= access & next_err;
        end
    end

    // read data loads only on a read, so it holds between reads
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && access && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // gated by master enable; detection runs regardless
    assign gated_request = change_irq_summary_flag & change_irq_master_enable;

    // change interrupt registered so the pin comes from a flop
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            change_irq <= 1'b0;
        end else if (clk_en) begin
            change_irq <= gated_request;
        end
    end

    // wake when enabled, flags set first
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_req <= 1'b0;
        end else if (clk_en) begin
            wake_req <= gated_request;
        end
    end

    // event interrupt, one cycle behind the status it reflects
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule

`default_nettype wire

// ### rtl/pin_change_regs.vh
`ifndef PIN_CHANGE_REGS_VH
`define PIN_CHANGE_REGS_VH

// register byte addresses (word aligned)
`define ADDR_FIRST_RISE 12'h000
`define ADDR_FIRST_FALL 12'h004
`define ADDR_FIRST_FLAGS 12'h008
`define ADDR_SECOND_RISE 12'h00c
`define ADDR_SECOND_FALL 12'h010
`define ADDR_SECOND_FLAGS 12'h014
`define ADDR_IRQ_CONTROL 12'h018
`define ADDR_IRQ_STATUS 12'h01c
`define ADDR_IRQ_MASK 12'h020

// implemented bits of each port register
`define FIRST_PORT_MASK 8'h3f
`define SECOND_PORT_MASK 8'hf0
`define REG_RESET 8'h00

// control register: bit 0 master enable, bit 1 summary flag (read only)
`define CTRL_MASTER_BIT 0
`define CTRL_SUMMARY_BIT 1

// status / mask layout: bit 0 first port event, bit 1 second port event
`define EVT_WIDTH 2
`define EVT_FIRST_BIT 0
`define EVT_SECOND_BIT 1

`endif

// ### rtl/pin_sync_edge.v
`timescale 1ns/100ps
`default_nettype none
`include "pin_change_regs.vh"

module pin_sync_edge #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] sync;
    reg [WIDTH-1:0] prev;

    // two-stage synchroniser, then one history stage for comparison
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            sync <= {WIDTH{1'b0}};
            prev <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    // one-cycle pulses per pin; only sync and prev are compared
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_edge
            assign rise[i] = sync[i] & ~prev[i];
            assign fall[i] = ~sync[i] & prev[i];
        end
    endgenerate
endmodule

`default_nettype wire

// ### tb/pin_change_interrupt_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pin_change_regs.vh"
module pin_change_interrupt_tb;
    logic core_clk, nrst, psel, penable, pwrite, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdv;
    logic [5:0] la;
    logic [7:4] lb;
    logic [63:0] rows [0:4];
    wire [31:0] prdata;
    wire pready, pslverr, change_irq, wake_req, irq;
    wire [5:0] pa;
    wire [7:4] pb;
    int failures, total_checks, i;
    pin_source pin_source_i (.level_a(la), .level_b(lb), .first_port_pin(pa),
        .second_port_pin(pb));
    pin_change_interrupt pin_change_interrupt_i (.core_clk(core_clk), .nrst(nrst),
        .clk_en(1'b1), .first_port_pin(pa), .second_port_pin(pb), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .change_irq(change_irq), .wake_req(wake_req),
        .irq(irq));
    task report_and_stop;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; request held until pready is seen high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            failures++;
            report_and_stop;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask
    task rd(input logic [11:0] a);
        bus(0, a, 0);
    endtask
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        // rise en a, fall en a, rise en b, fall en b, pins a, pins b, flags a, flags b
        rows[0] = 64'hff00ff0015501550;
        rows[1] = 64'h00ff00ff00001550;
        rows[2] = 64'h000000003ff00000;
        rows[3] = 64'hffffffff2aa01550;
        rows[4] = 64'h3f00f00015501550;
        {nrst, psel, penable, pwrite, paddr, pwdata, la, lb} = 0;
        failures = 0;
        total_checks = 0;
        repeat (2) @(posedge core_clk);
        nrst <= 1;
        repeat (3) @(posedge core_clk);
        for (i = 0; i <= 32; i += 4) begin
            rd(i[11:0]);
            check(rdv, 0);
        end
        for (i = 0; i < 5; i++) begin
            wr(`ADDR_FIRST_RISE, rows[i][63:56]);
            wr(`ADDR_FIRST_FALL, rows[i][55:48]);
            wr(`ADDR_SECOND_RISE, rows[i][47:40]);
            wr(`ADDR_SECOND_FALL, rows[i][39:32]);
            wr(`ADDR_FIRST_FLAGS, 0);
            wr(`ADDR_SECOND_FLAGS, 0);
            rd(`ADDR_FIRST_RISE);
            check(rdv, rows[i][63:56] & `FIRST_PORT_MASK);
            rd(`ADDR_SECOND_FALL);
            check(rdv, rows[i][39:32] & `SECOND_PORT_MASK);
            @(posedge core_clk);
            la <= rows[i][29:24];
            lb <= rows[i][23:20];
            repeat (6) @(posedge core_clk);
            rd(`ADDR_FIRST_FLAGS);
            check(rdv, rows[i][15:8]);
            rd(`ADDR_SECOND_FLAGS);
            check(rdv, rows[i][7:0]);
        end
        // master on with flags pending, then clear port by port
        wr(`ADDR_IRQ_CONTROL, 1);
        // request flop loads one edge after the enable lands
        @(posedge core_clk);
        check(wake_req, 1);
        rd(`ADDR_FIRST_FLAGS);
        wr(`ADDR_FIRST_FLAGS, rdv & (rdv ^ 32'hff));
        rd(`ADDR_IRQ_CONTROL);
        check(rdv, 3);
        wr(`ADDR_SECOND_FLAGS, 0);
        rd(`ADDR_IRQ_CONTROL);
        check(rdv, 1);
        check(change_irq, 0);
        // master off: flags still collect, no request
        wr(`ADDR_IRQ_CONTROL, 0);
        la <= 6'h3f;
        repeat (6) @(posedge core_clk);
        rd(`ADDR_FIRST_FLAGS);
        check(rdv, 32'h2a);
        check(change_irq, 0);
        rd(`ADDR_IRQ_CONTROL);
        check(rdv, 2);
        // edge lands while software clears
        la <= 0;
        @(posedge core_clk);
        la <= 6'h01;
        wr(`ADDR_FIRST_FLAGS, 0);
        repeat (4) @(posedge core_clk);
        rd(`ADDR_FIRST_FLAGS);
        check(rdv, 1);
        // sticky events, mask and write-one clear
        rd(`ADDR_IRQ_STATUS);
        check(rdv, 3);
        wr(`ADDR_IRQ_MASK, 1);
        @(posedge core_clk);
        check(irq, 1);
        wr(`ADDR_IRQ_STATUS, 1);
        rd(`ADDR_IRQ_STATUS);
        check(rdv, 2);
        check(irq, 0);
        rd(12'h040);
        check(errv, 1);
        // reset in mid-run clears everything
        nrst <= 0;
        @(posedge core_clk);
        check(irq, 0);
        nrst <= 1;
        repeat (3) @(posedge core_clk);
        rd(`ADDR_FIRST_FLAGS);
        check(rdv, 0);
        report_and_stop;
    end
endmodule
`default_nettype wire

// ### tb/pin_change_props.sv
`timescale 1ns/100ps
`default_nettype none
module pin_change_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [5:0] first_port_pin,
    input wire logic [7:4] second_port_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic change_irq,
    input wire logic wake_req,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // bus answer, refusal and read data
    chk_ready_next: assert property (psel && penable && !pready && clk_en |=> pready ##1 !pready)
        else $error("bus answer late or longer than one cycle");
    chk_err_unmapped: assert property (pslverr |-> pready && paddr > 12'h020)
        else $error("error answer on a mapped address");
    chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
        else $error("read data moved without a read");
    // interrupt lines only drop on software writes, only rise with a cause
    chk_wake_match: assert property (wake_req == change_irq)
        else $error("wake request differs from change interrupt");
    chk_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite))
        else $error("interrupt dropped without a write");
    chk_cirq_fall: assert property ($fell(change_irq) |-> $past(pready && pwrite))
        else $error("change interrupt dropped without a write");
    chk_cirq_cause: assert property ($rose(change_irq) |-> $past(pready && pwrite) ||
        $past({first_port_pin, second_port_pin}, 4) != $past({first_port_pin, second_port_pin}, 5))
        else $error("change interrupt rose without a cause");
endmodule
bind pin_change_interrupt pin_change_props pin_change_props_i (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .first_port_pin(first_port_pin), .second_port_pin(second_port_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .change_irq(change_irq),
    .wake_req(wake_req), .irq(irq));
`default_nettype wire

// ### tb/pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module pin_source (
    input wire logic [5:0] level_a,
    input wire logic [7:4] level_b,
    output logic [5:0] first_port_pin,
    output logic [7:4] second_port_pin
);
    // push-pull drivers: a level holds until moved, no released state
    assign first_port_pin = level_a;
    assign second_port_pin = level_b;
endmodule
`default_nettype wire
